/* rtl/fieldbus_cfg_pkg.sv */
// shared constants and types for the fieldbus slave configuration block
package fieldbus_cfg_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned TIMEOUT_SHOW_MS = 3000;
  localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMEOUT_SHOW_CYCLES = TIMEOUT_SHOW_MS * (CLK_HZ / 1000);

  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CONDITION = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_LED_STATE = 8'h0C;

  localparam int NODE_ID_LSB = 0;
  localparam int NODE_ID_W = 6;
  localparam int RATE_SW_LSB = 6;
  localparam int RATE_W = 2;
  localparam int CFG_RATE_LSB = 8;
  localparam int CFG_GROUP2_BIT = 12;
  localparam int CFG_MASTER_BIT = 13;

  localparam int COND_BASE_LINKED = 0;
  localparam int COND_BASE_COMM_FAIL = 1;
  localparam int COND_HW_FAULT = 2;
  localparam int COND_MASTER_CONN = 3;
  localparam int COND_DUP_ID_FAIL = 4;
  localparam int COND_COMM_RESTART = 5;
  localparam int COND_SOLE_NODE = 6;
  localparam int COND_W = 7;
  localparam logic [COND_W-1:0] COND_RESET = 7'h00;

  localparam int EVT_IO_TIMEOUT = 0;
  localparam int LED_MS_LSB = 0;
  localparam int LED_NS_LSB = 4;
  localparam int LED_TMO_BIT = 8;

  localparam logic [1:0] RATE_125K = 2'h0;
  localparam logic [1:0] RATE_250K = 2'h1;
  localparam logic [1:0] RATE_500K = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    LED_OFF,
    LED_GREEN_ON,
    LED_GREEN_FLASH,
    LED_RED_FLASH,
    LED_RED_ON
  } led_mode_t;

  function automatic logic [1:0] decode_rate(input logic [1:0] sw);
    case (sw)
      2'h1: decode_rate = RATE_250K;
      2'h2: decode_rate = RATE_500K;
      default: decode_rate = RATE_125K;
    endcase
  endfunction : decode_rate

endpackage : fieldbus_cfg_pkg

/* rtl/flash_prescaler.sv */
// common flash rate divider with equal on and off halves
`timescale 1ns/10ps
module flash_prescaler #(
  parameter int unsigned HALF_CYCLES = fieldbus_cfg_pkg::FLASH_HALF_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic flash_on
);
  import fieldbus_cfg_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic phase;
  } presc_state_t;

  presc_state_t st_ff;
  presc_state_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (st_ff.cnt >= 32'(HALF_CYCLES - 1))
    begin
      nxt_st.cnt = 32'h0000_0000;
      nxt_st.phase = ~st_ff.phase;
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign flash_on = st_ff.phase;
endmodule : flash_prescaler

/* rtl/bicolour_led_driver.sv */
// drives one green/red indicator pair from a display mode
`timescale 1ns/10ps
module bicolour_led_driver (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fieldbus_cfg_pkg::led_mode_t mode,
  input wire logic flash_on,
  output logic green,
  output logic red
);
  import fieldbus_cfg_pkg::*;

  typedef struct packed {
    logic green;
    logic red;
  } drv_state_t;

  drv_state_t st_ff;
  drv_state_t nxt_st;

  always_comb
  begin
    nxt_st = '0;
    case (mode)
      LED_GREEN_ON: nxt_st.green = 1'b1;
      LED_GREEN_FLASH: nxt_st.green = flash_on;
      LED_RED_FLASH: nxt_st.red = flash_on;
      LED_RED_ON: nxt_st.red = 1'b1;
      default: nxt_st = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign green = st_ff.green;
  assign red = st_ff.red;
endmodule : bicolour_led_driver

/* rtl/fieldbus_slave_config_status.sv */
// fieldbus slave adapter: switch decoding, status indicators, register slave
//
// Summary of operation
// - the node identifier is the 6-bit value on switch positions 6..1, range 0 to 63.
// - switch positions 8..7 pick the bit rate, 00=125K, 01=250K, 10=500K, 11 falls back to 125K.
// - the adapter acts only as a group 2 restricted slave and never as a master.
// - adapter and base unit together show up on the network as one single slave node.
// - the module indicator is steady green in normal operation.
// - the module indicator flashes green when no base unit connection is seen.
// - the module indicator flashes red when the base unit is linked but communication fails.
// - the module indicator is steady red on an internal hardware fault.
// - the network indicator is steady green when normal and connected to the master.
// - the network indicator flashes green when normal but without master or released.
// - the network indicator flashes red after an I/O timeout, back to green flash a few seconds later.
// - the network indicator is steady red on a failed duplicate id check or a forced restart.
// - the network indicator stays off when the adapter is the only node on the network.
`timescale 1ns/10ps
module fieldbus_slave_config_status #(
  parameter int unsigned FLASH_HALF = fieldbus_cfg_pkg::FLASH_HALF_CYCLES,
  parameter int unsigned TIMEOUT_SHOW = fieldbus_cfg_pkg::TIMEOUT_SHOW_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] config_switch_bank,
  output logic [5:0] node_id,
  output logic [1:0] bit_rate_sel,
  output logic group2_slave_only,
  output logic module_status_led_green,
  output logic module_status_led_red,
  output logic network_status_led_green,
  output logic network_status_led_red,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import fieldbus_cfg_pkg::*;

  typedef struct packed {
    logic sampled;
    logic [NODE_ID_W-1:0] node_id;
    logic [RATE_W-1:0] rate;
    logic [COND_W-1:0] cond;
    logic tmo_active;
    logic [31:0] tmo_cnt;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;
  led_mode_t ms_mode;
  led_mode_t ns_mode;
  logic flash_on;
  logic [31:0] cfg_word;
  logic [31:0] led_word;
  logic [31:0] wr_merged;

  // shared flash timing for both indicators
  flash_prescaler #(
    .HALF_CYCLES(FLASH_HALF)
  ) u_flash (
    .aclk(aclk),
    .aresetn(aresetn),
    .flash_on(flash_on)
  );

  // module indicator priority
  always_comb
  begin
    if (st_ff.cond[COND_HW_FAULT])
      ms_mode = LED_RED_ON;
    else if (!st_ff.cond[COND_BASE_LINKED])
      ms_mode = LED_GREEN_FLASH;
    else if (st_ff.cond[COND_BASE_COMM_FAIL])
      ms_mode = LED_RED_FLASH;
    else
      ms_mode = LED_GREEN_ON;
  end

  // network indicator priority
  always_comb
  begin
    if (st_ff.cond[COND_DUP_ID_FAIL] || st_ff.cond[COND_COMM_RESTART])
      ns_mode = LED_RED_ON;
    else if (st_ff.cond[COND_SOLE_NODE])
      ns_mode = LED_OFF;
    else if (st_ff.tmo_active)
      ns_mode = LED_RED_FLASH;
    else if (st_ff.cond[COND_MASTER_CONN])
      ns_mode = LED_GREEN_ON;
    else
      ns_mode = LED_GREEN_FLASH;
  end

  bicolour_led_driver u_ms_led (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(ms_mode),
    .flash_on(flash_on),
    .green(module_status_led_green),
    .red(module_status_led_red)
  );

  bicolour_led_driver u_ns_led (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(ns_mode),
    .flash_on(flash_on),
    .green(network_status_led_green),
    .red(network_status_led_red)
  );

  // readback words
  always_comb
  begin
    cfg_word = 32'h0000_0000;
    cfg_word[NODE_ID_LSB +: NODE_ID_W] = st_ff.node_id;
    cfg_word[CFG_RATE_LSB +: RATE_W] = st_ff.rate;
    cfg_word[CFG_GROUP2_BIT] = 1'b1;
    cfg_word[CFG_MASTER_BIT] = 1'b0;
    led_word = 32'h0000_0000;
    led_word[LED_MS_LSB +: 3] = ms_mode;
    led_word[LED_NS_LSB +: 3] = ns_mode;
    led_word[LED_TMO_BIT] = st_ff.tmo_active;
  end

  // byte-lane merge for the condition register
  always_comb
  begin
    wr_merged = {25'h000_0000, st_ff.cond};
    for (int b = 0; b < 4; b++)
    begin
      if (st_ff.wstrb[b])
        wr_merged[b*8 +: 8] = st_ff.wdata[b*8 +: 8];
    end
  end

  always_comb
  begin
    nxt_st = st_ff;
    // capture the switches in the first cycle after reset only
    if (!st_ff.sampled)
    begin
      nxt_st.sampled = 1'b1;
      nxt_st.node_id = config_switch_bank[NODE_ID_LSB +: NODE_ID_W];
      nxt_st.rate = decode_rate(config_switch_bank[RATE_SW_LSB +: RATE_W]);
    end
    // timeout display window
    if (st_ff.tmo_active)
    begin
      if (st_ff.tmo_cnt >= 32'(TIMEOUT_SHOW - 1))
      begin
        nxt_st.tmo_active = 1'b0;
        nxt_st.tmo_cnt = 32'h0000_0000;
      end
      else
        nxt_st.tmo_cnt = st_ff.tmo_cnt + 32'h0000_0001;
    end
    // write address and data, either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.aw_got && st_ff.w_got)
    begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      case (st_ff.awaddr)
        OFS_CONDITION: nxt_st.cond = wr_merged[COND_W-1:0];
        OFS_EVENT:
        begin
          if (st_ff.wstrb[0] && st_ff.wdata[EVT_IO_TIMEOUT])
          begin
            nxt_st.tmo_active = 1'b1;
            nxt_st.tmo_cnt = 32'h0000_0000;
            // timed-out connection no longer held
            nxt_st.cond[COND_MASTER_CONN] = 1'b0;
          end
        end
        OFS_CONFIG, OFS_LED_STATE: nxt_st.bresp = RESP_OKAY;
        default: nxt_st.bresp = RESP_SLVERR;
      endcase
    end
    if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;
    // read channel
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      case (s_axi_araddr[7:0])
        OFS_CONFIG: nxt_st.rdata = cfg_word;
        OFS_CONDITION: nxt_st.rdata = {25'h000_0000, st_ff.cond};
        OFS_EVENT: nxt_st.rdata = 32'h0000_0000;
        OFS_LED_STATE: nxt_st.rdata = led_word;
        default:
        begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (st_ff.rvalid && s_axi_rready)
    begin
      nxt_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
      st_ff.cond <= COND_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  // one slave identity on the network, taken from the switches only
  assign node_id = st_ff.node_id;
  assign bit_rate_sel = st_ff.rate;
  assign group2_slave_only = 1'b1;
endmodule : fieldbus_slave_config_status

/* tb/switch_bank_model.sv */
// operator switch bank model in front of the adapter
`timescale 1ns/10ps
module switch_bank_model (
  input wire logic aclk,
  input wire logic [7:0] setting,
  output logic [7:0] config_switch_bank
);
  // contacts settle one clock after a move
  always_ff @(posedge aclk)
    config_switch_bank <= setting;
endmodule : switch_bank_model

/* tb/fieldbus_slave_config_status_assertions.sv */
// port checks for the fieldbus slave configuration block
`timescale 1ns/10ps
module fieldbus_slave_config_status_assertions #(
  parameter int unsigned FLASH_HALF = 4,
  parameter int unsigned TIMEOUT_SHOW = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] config_switch_bank,
  input wire logic [5:0] node_id,
  input wire logic [1:0] bit_rate_sel,
  input wire logic group2_slave_only,
  input wire logic module_status_led_green,
  input wire logic module_status_led_red,
  input wire logic network_status_led_green,
  input wire logic network_status_led_red,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic [1:0] sw;
  assign sw = config_switch_bank[7:6];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_group2_only: assert property (group2_slave_only)
    else $error("group2 flag low");
  chk_id_capture: assert property ($past(aresetn) && !$past(aresetn, 2)
    |-> node_id == $past(config_switch_bank[5:0])) else $error("node id wrong");
  chk_rate_capture: assert property ($past(aresetn) && !$past(aresetn, 2)
    |-> bit_rate_sel == ((&$past(sw)) ? 2'h0 : $past(sw))) else $error("rate wrong");
  chk_ids_held: assert property ($past(aresetn) && $past(aresetn, 2)
    |-> $stable(node_id) && $stable(bit_rate_sel)) else $error("ids moved");
  chk_one_colour: assert property (!(module_status_led_green && module_status_led_red)
    && !(network_status_led_green && network_status_led_red)) else $error("both colours lit");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("no write answer");
  chk_leds_dark: assert property (disable iff (1'b0) !aresetn |=> !module_status_led_green
    && !module_status_led_red && !network_status_led_green && !network_status_led_red)
    else $error("led lit in reset");
endmodule : fieldbus_slave_config_status_assertions
bind fieldbus_slave_config_status fieldbus_slave_config_status_assertions #(
  .FLASH_HALF(FLASH_HALF), .TIMEOUT_SHOW(TIMEOUT_SHOW)) assertions_i (.aclk, .aresetn,
  .config_switch_bank, .node_id, .bit_rate_sel, .group2_slave_only, .module_status_led_green,
  .module_status_led_red, .network_status_led_green, .network_status_led_red, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid);

/* tb/fieldbus_slave_config_status_tb_top.sv */
// self-checking bench for the fieldbus slave configuration block
`timescale 1ns/10ps
module fieldbus_slave_config_status_tb_top;
  import fieldbus_cfg_pkg::*;
  localparam int FH = 4;
  localparam int TS = 20;
  localparam logic [6:0] CND [8] = '{7'h00, 7'h01, 7'h03, 7'h07, 7'h09, 7'h19, 7'h29, 7'h49};
  localparam logic [7:0] LST [8] = '{8'h22, 8'h21, 8'h23, 8'h24, 8'h11, 8'h41, 8'h41, 8'h01};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] setting = 8'h00;
  logic [7:0] sw;
  logic [5:0] node_id;
  logic [1:0] bit_rate_sel, s_axi_bresp, s_axi_rresp;
  logic group2_slave_only, mod_g, mod_r, net_g, net_r;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int fails = 0;
  int compares = 0;
  always #5 aclk = ~aclk;
  switch_bank_model switch_bank_model_i (.aclk, .setting, .config_switch_bank(sw));
  fieldbus_slave_config_status #(.FLASH_HALF(FH), .TIMEOUT_SHOW(TS)) fieldbus_slave_config_status_i (
    .aclk, .aresetn, .config_switch_bank(sw), .node_id, .bit_rate_sel, .group2_slave_only,
    .module_status_led_green(mod_g), .module_status_led_red(mod_r), .network_status_led_green(net_g),
    .network_status_led_red(net_r), .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic bail;
    fails++;
    $display("unexpected %0t: bus timeout", $time);
    close_out();
  endtask : bail
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    if (n == 50)
      bail();
    cmp({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {24'h00_0000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    if (n == 50)
      bail();
    cmp(s_axi_rdata, ed);
    cmp({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask : rd
  function automatic logic [15:0] want(input logic [2:0] m);
    case (m)
      3'h1: want = {8'(2 * FH), 8'h00};
      3'h2: want = {8'(FH), 8'h00};
      3'h3: want = {8'h00, 8'(FH)};
      3'h4: want = {8'h00, 8'(2 * FH)};
      default: want = 16'h0000;
    endcase
  endfunction : want
  // lit cycles per colour over one flash period
  task automatic leds(input logic [7:0] st);
    logic [7:0] c [4];
    c = '{default: 8'h00};
    repeat (2 * FH)
    begin
      @(posedge aclk);
      c[0] += {7'h00, mod_g};
      c[1] += {7'h00, mod_r};
      c[2] += {7'h00, net_g};
      c[3] += {7'h00, net_r};
    end
    cmp({c[0], c[1], c[2], c[3]}, {want(st[2:0]), want(st[6:4])});
  endtask : leds
  initial
  begin
    int i;
    for (i = 0; i < 4; i++)
    begin
      setting <= {i[1:0], 6'(i * 21)};
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_CONFIG, {18'h0_0000, 2'h1, 2'h0, (i == 3) ? 2'h0 : i[1:0], 2'h0, 6'(i * 21)}, RESP_OKAY);
      setting <= ~setting;
      repeat (4) @(posedge aclk);
      cmp({23'h00_0000, group2_slave_only, bit_rate_sel, node_id},
        {23'h00_0000, 1'b1, (i == 3) ? 2'h0 : i[1:0], 6'(i * 21)});
    end
    rd(OFS_CONDITION, 32'h0000_0000, RESP_OKAY);
    wr(OFS_CONFIG, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFS_CONFIG, 32'h0000_103F, RESP_OKAY);
    wr(8'h10, 32'h0000_0001, RESP_SLVERR);
    rd(8'h10, 32'h0000_0000, RESP_SLVERR);
    for (i = 0; i < 8; i++)
    begin
      wr(OFS_CONDITION, {25'h000_0000, CND[i]}, RESP_OKAY);
      rd(OFS_LED_STATE, {24'h00_0000, LST[i]}, RESP_OKAY);
      leds(LST[i]);
    end
    wr(OFS_CONDITION, 32'h0000_0009, RESP_OKAY);
    wr(OFS_EVENT, 32'h0000_0001, RESP_OKAY);
    rd(OFS_LED_STATE, 32'h0000_0131, RESP_OKAY);
    leds(8'h31);
    repeat (TS) @(posedge aclk);
    rd(OFS_LED_STATE, 32'h0000_0021, RESP_OKAY);
    rd(OFS_CONDITION, 32'h0000_0001, RESP_OKAY);
    rd(OFS_EVENT, 32'h0000_0000, RESP_OKAY);
    // no byte lanes enabled: neither write may take effect
    s_axi_wstrb <= 4'h0;
    wr(OFS_EVENT, 32'h0000_0001, RESP_OKAY);
    wr(OFS_CONDITION, 32'h0000_007F, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(OFS_LED_STATE, 32'h0000_0021, RESP_OKAY);
    close_out();
  end
endmodule : fieldbus_slave_config_status_tb_top
